// File: shared/cpwm_pkg.sv
package cpwm_pkg;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   // reset values of the compare registers
   localparam logic [15:0] HALF_PERIOD_RST = 16'hffff;
   localparam logic [15:0] CHANGE_POINT_RST = 16'hffff;
   // clock source select codes for the paired counters
   localparam logic [1:0] CLK_SEL_DIV1 = 2'h0;
   localparam logic [1:0] CLK_SEL_DIV2 = 2'h1;
   localparam logic [1:0] CLK_SEL_DIV4 = 2'h2;
   localparam logic [1:0] CLK_SEL_DIV8 = 2'h3;
   localparam int PRESCALE_W = 3;
   // counter start bit positions
   localparam int START_AUX = 0;
   localparam int START_LEAD = 1;
   localparam int START_TRAIL = 2;
   // output master enable bit positions
   localparam int OE_LEAD_POS = 0;
   localparam int OE_LEAD_NEG = 1;
   localparam int OE_TRAIL_POS_A = 2;
   localparam int OE_TRAIL_NEG_A = 3;
   localparam int OE_POS_B = 4;
   localparam int OE_TRAIL_NEG_B = 5;
   localparam int OE_W = 6;
   // aux capture edge select codes
   localparam logic [1:0] CAP_OFF = 2'h0;
   localparam logic [1:0] CAP_RISE = 2'h1;
   localparam logic [1:0] CAP_FALL = 2'h2;
   localparam logic [1:0] CAP_BOTH = 2'h3;
   // timing figures at 16 MHz reference clock
   localparam real PHI_PERIOD_NS = 62.5;
   localparam real MIN_PERIOD_NS = 375.0;
   localparam real MAX_PERIOD_MS = 8.19;
endpackage : cpwm_pkg

// File: src/cpwm_counter.sv
`timescale 1ns/1ns
module cpwm_counter (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic tick,
   input wire logic load,
   input wire logic [15:0] load_value,
   input wire logic [15:0] top,
   // state
   output logic [15:0] count_q,
   output logic down_q
);
   logic [15:0] count_d;
   logic down_d;

   // up to the half period, then back down to zero
   always_comb begin
      count_d = count_q;
      down_d = down_q;
      if (load) begin
         count_d = load_value;
         down_d = 1'b0;
      end else if (run && tick) begin
         if (!down_q) begin
            if (count_q >= top) begin
               down_d = 1'b1;
               count_d = count_q - cpwm_pkg::CNT_ONE;
            end else begin
               count_d = count_q + cpwm_pkg::CNT_ONE;
            end
         end else begin
            if (count_q == cpwm_pkg::CNT_ZERO) begin
               down_d = 1'b0;
               count_d = cpwm_pkg::CNT_ONE;
            end else begin
               count_d = count_q - cpwm_pkg::CNT_ONE;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count_q <= cpwm_pkg::CNT_ZERO;
         down_q <= 1'b0;
      end else begin
         count_q <= count_d;
         down_q <= down_d;
      end
   end
endmodule : cpwm_counter

// File: src/cpwm_prescaler.sv
`timescale 1ns/1ns
module cpwm_prescaler (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // select
   input wire logic [1:0] clk_sel,
   // tick
   output logic tick
);
   logic [2:0] div_q;
   logic [2:0] div_d;

   always_comb begin
      div_d = div_q + 3'h1;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_d;
      end
   end

   // free-running divider; enable pulses only, no derived clocks
   always_comb begin
      unique case (clk_sel)
         cpwm_pkg::CLK_SEL_DIV1: tick = 1'b1;
         cpwm_pkg::CLK_SEL_DIV2: tick = (div_q[0] == 1'b1);
         cpwm_pkg::CLK_SEL_DIV4: tick = (div_q[1:0] == 2'h3);
         cpwm_pkg::CLK_SEL_DIV8: tick = (div_q == 3'h7);
      endcase
   end
endmodule : cpwm_prescaler

// File: src/cpwm_three_phase.sv
`timescale 1ns/1ns
module cpwm_three_phase (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // configuration
   input wire logic [2:0] counter_start_reg,
   input wire logic function_control_reg,
   input wire logic [5:0] output_master_enable_reg,
   input wire logic output_control_reg,
   input wire logic [1:0] aux_capture_control,
   input wire logic [1:0] lead_clock_control,
   input wire logic [1:0] trail_clock_control,
   // counter and compare writes
   input wire logic lead_counter_wr,
   input wire logic trail_counter_wr,
   input wire logic [15:0] counter_wdata,
   input wire logic [15:0] half_period_compare,
   input wire logic [15:0] lead_change_point,
   input wire logic [15:0] trail_change_point_a,
   input wire logic [15:0] trail_change_point_b,
   input wire logic shutdown_clear,
   // external trigger pin
   input wire logic aux_capture_pin,
   // general port levels used when the timer gives up the pins
   input wire logic [5:0] port_data,
   // phase outputs
   output logic lead_positive_pin,
   output logic lead_negative_pin,
   output logic trail_positive_pin_a,
   output logic trail_negative_pin_a,
   output logic positive_pin_b,
   output logic trail_negative_pin_b,
   output logic [5:0] timer_owns_pin,
   // status
   output logic [15:0] lead_counter,
   output logic [15:0] trail_counter,
   output logic aux_captured,
   output logic [15:0] aux_capture_value
);
   logic lead_tick;
   logic trail_tick;
   logic [15:0] lead_cnt;
   logic [15:0] trail_cnt;
   logic lead_down;
   logic trail_down;
   logic [15:0] aux_cnt_q;
   logic [15:0] aux_cnt_d;
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic cap_event;
   logic shut_q;
   logic shut_d;
   logic [15:0] cap_q;
   logic [15:0] cap_d;
   logic [2:0] pos_q;
   logic [2:0] pos_d;
   logic [2:0] neg_q;
   logic [2:0] neg_d;
   logic [5:0] pins_d;
   logic [5:0] pins_q;
   logic [5:0] own_d;
   logic [5:0] own_q;
   logic [15:0] lead_cnt_q;
   logic [15:0] trail_cnt_q;
   logic [15:0] point [3];
   logic lead_run;
   logic trail_run;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_SHUT = 3'b100
   } mode_t;
   mode_t mode_q;
   mode_t mode_d;

   // true when the counter lands on a compare value on this tick
   function automatic logic hit(input logic [15:0] cnt, input logic [15:0] cmp, input logic tk,
                                input logic en);
      hit = en && tk && (cnt == cmp);
   endfunction : hit

   // counters stop while shut down; compare hits only count while a counter runs
   assign lead_run = counter_start_reg[cpwm_pkg::START_LEAD] && mode_q != ST_SHUT;
   assign trail_run = counter_start_reg[cpwm_pkg::START_TRAIL] && mode_q != ST_SHUT;

   cpwm_prescaler u_lead_pre (
      .mclk(mclk),
      .rst(rst),
      .clk_sel(lead_clock_control),
      .tick(lead_tick)
   );

   cpwm_prescaler u_trail_pre (
      .mclk(mclk),
      .rst(rst),
      .clk_sel(trail_clock_control),
      .tick(trail_tick)
   );

   // period = 2 x half_period_compare prescaler ticks; 6..131070 counts, at 62.5 ns with CLK_SEL_DIV1
   cpwm_counter u_lead_cnt (
      .mclk(mclk),
      .rst(rst),
      .run(lead_run),
      .tick(lead_tick),
      .load(lead_counter_wr),
      .load_value(counter_wdata),
      .top(half_period_compare),
      .count_q(lead_cnt),
      .down_q(lead_down)
   );

   cpwm_counter u_trail_cnt (
      .mclk(mclk),
      .rst(rst),
      .run(trail_run),
      .tick(trail_tick),
      .load(trail_counter_wr),
      .load_value(counter_wdata),
      .top(half_period_compare),
      .count_q(trail_cnt),
      .down_q(trail_down)
   );

   // phase 0 on lead change point, phases 1 and 2 on trailing A and B
   assign point[0] = lead_change_point;
   assign point[1] = trail_change_point_a;
   assign point[2] = trail_change_point_b;

   // aux channel free-running counter, captured on the chosen edge
   always_comb begin
      aux_cnt_d = aux_cnt_q;
      if (counter_start_reg[cpwm_pkg::START_AUX]) begin
         aux_cnt_d = aux_cnt_q + cpwm_pkg::CNT_ONE;
      end
      unique case (aux_capture_control)
         cpwm_pkg::CAP_OFF: cap_event = 1'b0;
         cpwm_pkg::CAP_RISE: cap_event = sync2_q && !sync3_q;
         cpwm_pkg::CAP_FALL: cap_event = !sync2_q && sync3_q;
         cpwm_pkg::CAP_BOTH: cap_event = sync2_q ^ sync3_q;
      endcase
      cap_d = cap_event ? aux_cnt_q : cap_q;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aux_cnt_q <= cpwm_pkg::CNT_ZERO;
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         sync3_q <= 1'b1;
         cap_q <= cpwm_pkg::CNT_ZERO;
      end else begin
         aux_cnt_q <= aux_cnt_d;
         sync1_q <= aux_capture_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         cap_q <= cap_d;
      end
   end

   // mode sequencing; shutdown sticks until software clears it
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         ST_IDLE: begin
            if (function_control_reg) begin
               mode_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cap_event && output_control_reg) begin
               mode_d = ST_SHUT;
            end else if (!function_control_reg) begin
               mode_d = ST_IDLE;
            end
         end
         ST_SHUT: begin
            // a fresh capture beats the clear in the same cycle
            if (shutdown_clear && !(cap_event && output_control_reg)) begin
               mode_d = function_control_reg ? ST_RUN : ST_IDLE;
            end
         end
         default: mode_d = ST_IDLE;
      endcase
      shut_d = (mode_d == ST_SHUT);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q <= ST_IDLE;
         shut_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         shut_q <= shut_d;
      end
   end

   // set on a match counting up, clear on one counting down; the dead-time offset between
   // the two counters keeps positive and negative edges apart
   always_comb begin
      pos_d = pos_q;
      neg_d = neg_q;
      if (mode_q != ST_RUN) begin
         // at rest the negative leg is on, the complement of a low positive
         pos_d = 3'h0;
         neg_d = 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            // phase 0 sets positive from lead, phases 1 and 2 from trail; negative uses the other counter
            // a match counting up moves the leg towards positive, counting down towards negative,
            // so a restart or a counter halted on a match cannot invert the phase
            if (hit(i == 0 ? lead_cnt : trail_cnt, point[i], i == 0 ? lead_tick : trail_tick,
                    i == 0 ? lead_run : trail_run)) begin
               pos_d[i] = !(i == 0 ? lead_down : trail_down);
            end
            if (hit(i == 0 ? trail_cnt : lead_cnt, point[i], i == 0 ? trail_tick : lead_tick,
                    i == 0 ? trail_run : lead_run)) begin
               neg_d[i] = !(i == 0 ? trail_down : lead_down);
            end
            // 0% and 100%: a compare of zero or above half_period_compare forces a level
            // negative is active low, so its off level is 1
            if (point[i] == cpwm_pkg::CNT_ZERO) begin
               pos_d[i] = 1'b1;
               neg_d[i] = 1'b1;
            end else if (point[i] > half_period_compare) begin
               pos_d[i] = 1'b0;
               neg_d[i] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pos_q <= 3'h0;
         neg_q <= 3'h0;
      end else begin
         pos_q <= pos_d;
         neg_q <= neg_d;
      end
   end

   // pin mux: timer level only where enabled and not shut down;
   // positive is high-active, negative pin active low, never both active where the timer owns both pins of a leg
   always_comb begin
      own_d = (mode_q == ST_RUN && !shut_d) ? output_master_enable_reg : 6'h00;
      pins_d = port_data;
      if (own_d[cpwm_pkg::OE_LEAD_POS]) pins_d[0] = pos_d[0] && neg_d[0];
      if (own_d[cpwm_pkg::OE_LEAD_NEG]) pins_d[1] = neg_d[0] && pos_d[0] ? 1'b1 : neg_d[0];
      if (own_d[cpwm_pkg::OE_TRAIL_POS_A]) pins_d[2] = pos_d[1] && neg_d[1];
      if (own_d[cpwm_pkg::OE_TRAIL_NEG_A]) pins_d[3] = neg_d[1] && pos_d[1] ? 1'b1 : neg_d[1];
      if (own_d[cpwm_pkg::OE_POS_B]) pins_d[4] = pos_d[2] && neg_d[2];
      if (own_d[cpwm_pkg::OE_TRAIL_NEG_B]) pins_d[5] = neg_d[2] && pos_d[2] ? 1'b1 : neg_d[2];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pins_q <= 6'h00;
         own_q <= 6'h00;
         lead_cnt_q <= cpwm_pkg::CNT_ZERO;
         trail_cnt_q <= cpwm_pkg::CNT_ZERO;
      end else begin
         pins_q <= pins_d;
         own_q <= own_d;
         lead_cnt_q <= lead_cnt;
         trail_cnt_q <= trail_cnt;
      end
   end

   assign lead_positive_pin = pins_q[0];
   assign lead_negative_pin = pins_q[1];
   assign trail_positive_pin_a = pins_q[2];
   assign trail_negative_pin_a = pins_q[3];
   assign positive_pin_b = pins_q[4];
   assign trail_negative_pin_b = pins_q[5];
   assign timer_owns_pin = own_q;
   assign lead_counter = lead_cnt_q;
   assign trail_counter = trail_cnt_q;
   assign aux_captured = shut_q;
   assign aux_capture_value = cap_q;
endmodule : cpwm_three_phase

// File: testbench/cpwm_three_phase_sva.sv
`timescale 1ns/1ns
module cpwm_three_phase_sva (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // controls
   input wire logic [2:0] counter_start_reg,
   input wire logic function_control_reg,
   input wire logic [5:0] output_master_enable_reg,
   input wire logic output_control_reg,
   input wire logic [1:0] aux_capture_control,
   input wire logic [1:0] trail_clock_control,
   input wire logic lead_counter_wr,
   input wire logic trail_counter_wr,
   input wire logic [15:0] half_period_compare,
   input wire logic aux_capture_pin,
   input wire logic [5:0] port_data,
   // outputs
   input wire logic lead_positive_pin,
   input wire logic lead_negative_pin,
   input wire logic trail_positive_pin_a,
   input wire logic trail_negative_pin_a,
   input wire logic positive_pin_b,
   input wire logic trail_negative_pin_b,
   input wire logic [5:0] timer_owns_pin,
   input wire logic [15:0] lead_counter,
   input wire logic [15:0] trail_counter,
   input wire logic aux_captured
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic [5:0] pins;
   logic [5:0] own;
   assign pins = {trail_negative_pin_b, positive_pin_b, trail_negative_pin_a, trail_positive_pin_a,
      lead_negative_pin, lead_positive_pin};
   assign own = timer_owns_pin;
   // negative pins are active low
   a_leg_no_overlap: assert property (({pins[4], pins[2], pins[0]} & ~{pins[5], pins[3], pins[1]}
      & {own[4], own[2], own[0]} & {own[5], own[3], own[1]}) == 3'h0)
      else $error("both switches of a leg driven on");
   a_mask_owns: assert property ((own & ~$past(output_master_enable_reg)) == 6'h00)
      else $error("pin owned while its enable is low");
   a_port_release: assert property (own == 6'h00 && $past(own) == 6'h00 && !$past(rst)
      |-> pins == $past(port_data))
      else $error("released pins do not follow port data");
   a_fall_capture: assert property (function_control_reg && output_control_reg && !aux_captured
      && aux_capture_control == cpwm_pkg::CAP_FALL && $fell(aux_capture_pin) |-> ##[2:5] aux_captured)
      else $error("falling edge did not shut the outputs down");
   a_blocked_shutdown: assert property ((!output_control_reg)[*6] |-> !$rose(aux_captured))
      else $error("shutdown while it is blocked");
   a_shut_owns: assert property (aux_captured ##1 aux_captured |-> own == 6'h00)
      else $error("timer still owns pins during shutdown");
   a_halt_holds: assert property ((!counter_start_reg[cpwm_pkg::START_LEAD] && !lead_counter_wr)[*2]
      |=> $stable(lead_counter))
      else $error("halted lead counter moved");
   a_top_turn: assert property (function_control_reg && counter_start_reg[cpwm_pkg::START_TRAIL]
      && !aux_captured && !trail_counter_wr && trail_clock_control == cpwm_pkg::CLK_SEL_DIV1
      && trail_counter == half_period_compare && $past(trail_counter) != half_period_compare
      |=> trail_counter == half_period_compare - 16'h0001)
      else $error("trail counter did not turn down at the half period");
endmodule : cpwm_three_phase_sva
bind cpwm_three_phase cpwm_three_phase_sva cpwm_three_phase_sva_i (.mclk, .rst, .counter_start_reg,
   .function_control_reg, .output_master_enable_reg, .output_control_reg, .aux_capture_control,
   .trail_clock_control, .lead_counter_wr, .trail_counter_wr, .half_period_compare, .aux_capture_pin,
   .port_data, .lead_positive_pin, .lead_negative_pin, .trail_positive_pin_a, .trail_negative_pin_a,
   .positive_pin_b, .trail_negative_pin_b, .timer_owns_pin, .lead_counter, .trail_counter, .aux_captured);

// File: testbench/power_stage_model.sv
`timescale 1ns/1ns
module power_stage_model (
   // clock
   input wire logic mclk,
   // gate drives, positive high-on, negative low-on
   input wire logic [5:0] gate,
   input wire logic clear,
   // measurements
   output int on_cnt [3],
   output int rise_cnt [3],
   output int shoot_cnt
);
   logic [2:0] last_q = 3'h0;
   always @(posedge mclk) begin
      if (clear)
         shoot_cnt = 0;
      for (int p = 0; p < 3; p++) begin
         if (clear) begin
            on_cnt[p] = 0;
            rise_cnt[p] = 0;
         end else begin
            on_cnt[p] += gate[2*p];
            rise_cnt[p] += gate[2*p] & ~last_q[p];
            // both switches of a leg on shorts the supply
            shoot_cnt += gate[2*p] & ~gate[2*p+1];
         end
         last_q[p] = gate[2*p];
      end
   end
endmodule : power_stage_model

// File: testbench/complementary_pwm_three_phase_bench.sv
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
   $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module complementary_pwm_three_phase_bench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] counter_start_reg = 3'h0;
   logic function_control_reg = 1'b0;
   logic [5:0] output_master_enable_reg = 6'h00;
   logic output_control_reg = 1'b0;
   logic [1:0] aux_capture_control = 2'h0;
   logic [1:0] lead_clock_control = 2'h0;
   logic [1:0] trail_clock_control = 2'h0;
   logic lead_counter_wr = 1'b0;
   logic trail_counter_wr = 1'b0;
   logic [15:0] counter_wdata = 16'h0000;
   logic [15:0] half_period_compare = 16'h0000;
   logic [15:0] lead_change_point = 16'h0000;
   logic [15:0] trail_change_point_a = 16'h0000;
   logic [15:0] trail_change_point_b = 16'h0000;
   logic shutdown_clear = 1'b0;
   logic aux_capture_pin = 1'b1;
   logic [5:0] port_data = 6'h00;
   logic power_clear = 1'b1;
   wire [5:0] pins;
   logic [5:0] timer_owns_pin;
   logic [15:0] lead_counter;
   logic [15:0] trail_counter;
   logic aux_captured;
   logic [15:0] aux_capture_value;
   logic [5:0] notes [$];
   int on_cnt [3];
   int rise_cnt [3];
   int shoot_cnt;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   localparam logic [15:0] dead_time_value = 16'h0001;

   cpwm_three_phase cpwm_three_phase_i (.mclk, .rst, .counter_start_reg, .function_control_reg,
      .output_master_enable_reg, .output_control_reg, .aux_capture_control, .lead_clock_control,
      .trail_clock_control, .lead_counter_wr, .trail_counter_wr, .counter_wdata, .half_period_compare,
      .lead_change_point, .trail_change_point_a, .trail_change_point_b, .shutdown_clear, .aux_capture_pin,
      .port_data, .lead_positive_pin(pins[0]), .lead_negative_pin(pins[1]), .trail_positive_pin_a(pins[2]),
      .trail_negative_pin_a(pins[3]), .positive_pin_b(pins[4]), .trail_negative_pin_b(pins[5]),
      .timer_owns_pin, .lead_counter, .trail_counter, .aux_captured, .aux_capture_value);
   power_stage_model power_stage_model_i (.mclk, .gate(pins), .clear(power_clear), .on_cnt, .rise_cnt,
      .shoot_cnt);

   always #2 mclk = ~mclk;

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   // counters loaded while stopped, then started together
   task automatic start_pwm(input logic [15:0] h, p0, pa, pb, input logic [2:0] run);
      counter_start_reg = 3'h0;
      half_period_compare = h;
      lead_change_point = p0;
      trail_change_point_a = pa;
      trail_change_point_b = pb;
      counter_wdata = 16'h0000;
      trail_counter_wr = 1'b1;
      @(negedge mclk);
      trail_counter_wr = 1'b0;
      counter_wdata = dead_time_value;
      lead_counter_wr = 1'b1;
      @(negedge mclk);
      lead_counter_wr = 1'b0;
      counter_start_reg = run;
   endtask : start_pwm

   task automatic measure(input int n);
      power_clear = 1'b1;
      @(negedge mclk);
      power_clear = 1'b0;
      repeat (n) @(negedge mclk);
   endtask : measure

   // pins must fall back to the port levels noted when shutdown was armed
   initial begin
      logic prev;
      logic [5:0] exp;
      prev = 1'b0;
      forever begin
         @(negedge mclk);
         if (aux_captured === 1'b1 && prev !== 1'b1) begin
            exp = notes.size() > 0 ? notes.pop_front() : ~port_data;
            repeat (2) @(negedge mclk);
            `CHECK("released pins", exp, pins)
            `CHECK("owned after capture", 6'h00, timer_owns_pin)
         end
         prev = aux_captured;
      end
   end

   initial begin
      logic [15:0] pt [3];
      logic [1:0] code;
      int h;
      int n;
      logic [15:0] cap_first;
      void'($urandom(39906));
      port_data = 6'($urandom);
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      `CHECK("owns after reset", 6'h00, timer_owns_pin)
      function_control_reg = 1'b1;
      output_master_enable_reg = 6'h3f;
      // each phase in turn gets full, zero and a random mid duty
      for (int k = 0; k < 2; k++) begin
         h = k ? 40 : 3;
         for (int r = 0; r < 3; r++) begin
            pt[r] = 16'h0000;
            pt[(r + 1) % 3] = 16'(h + 1);
            pt[(r + 2) % 3] = 16'(2 + $urandom % (h - 2));
            start_pwm(16'(h), pt[0], pt[1], pt[2], 3'h7);
            repeat (4 * h) @(negedge mclk);
            `CHECK("owns running", 6'h3f, timer_owns_pin)
            measure(16 * h);
            `CHECK("shoot through", 0, shoot_cnt)
            `CHECK("full duty", 16 * h, on_cnt[r])
            `CHECK("zero duty", 0, on_cnt[(r + 1) % 3])
            n = rise_cnt[(r + 2) % 3];
            `CHECK("pulses per window", 1'b1, n >= 7 && n <= 9)
         end
      end
      repeat (4) begin
         output_master_enable_reg = 6'($urandom);
         port_data = 6'($urandom);
         repeat (3) @(negedge mclk);
         `CHECK("owned pins", output_master_enable_reg, timer_owns_pin)
      end
      output_master_enable_reg = 6'h3f;
      for (int c = 0; c < 4; c++) begin
         lead_clock_control = 2'(c);
         trail_clock_control = 2'(3 - c);
         start_pwm(16'h0fff, 16'h0800, 16'h0800, 16'h0800, 3'h2);
         repeat (64) @(negedge mclk);
         counter_start_reg = 3'h0;
         repeat (3) @(negedge mclk);
         n = lead_counter - dead_time_value;
         `CHECK("prescaled count", 1'b1, n >= (64 >> c) - 2 && n <= (64 >> c) + 1)
         `CHECK("halted trail", 16'h0000, trail_counter)
      end
      lead_clock_control = cpwm_pkg::CLK_SEL_DIV1;
      trail_clock_control = cpwm_pkg::CLK_SEL_DIV1;
      start_pwm(16'h0028, 16'h0010, 16'h0014, 16'h0018, 3'h7);
      // last pass uses a falling edge with shutdown blocked
      for (int c = 0; c < 5; c++) begin
         aux_capture_control = cpwm_pkg::CAP_OFF;
         aux_capture_pin = 1'b1;
         repeat (6) @(negedge mclk);
         shutdown_clear = 1'b1;
         @(negedge mclk);
         shutdown_clear = 1'b0;
         code = (c == 4) ? cpwm_pkg::CAP_FALL : 2'(c);
         aux_capture_control = code;
         output_control_reg = (c != 4);
         n = (c != 4) && (code == cpwm_pkg::CAP_FALL || code == cpwm_pkg::CAP_BOTH);
         if (n)
            notes.push_back(port_data);
         repeat (6) @(negedge mclk);
         aux_capture_pin = 1'b0;
         repeat (12) @(negedge mclk);
         `CHECK("shutdown", 1'(n), aux_captured)
         // aux counter runs through both captures, whose falls lie 25 clocks apart
         if (c == 2)
            cap_first = aux_capture_value;
         if (c == 3)
            `CHECK("capture spacing", 16'h0019, 16'(aux_capture_value - cap_first))
      end
      `CHECK("notes left", 0, notes.size())
      end_sim();
   end
endmodule : complementary_pwm_three_phase_bench
